/* File: core/lisw_pkg.sv */
package lisw_pkg;

  // parallel port register map
  localparam logic [7:0] LISW_ADDR_BYTE_ONE = 8'h18;
  localparam logic [7:0] LISW_ADDR_BYTE_TWO = 8'h19;
  localparam int         LISW_BYTE_W        = 8;
  localparam logic [7:0] LISW_RD_ZERO       = 8'h00;

  // bit counter
  localparam logic [2:0] LISW_BIT_FIRST = 3'h0;
  localparam logic [2:0] LISW_BIT_LAST  = 3'h7;

  // idle and active levels of the serial port
  localparam logic LISW_CS_IDLE   = 1'b1;
  localparam logic LISW_CS_ACTIVE = 1'b0;
  localparam logic LISW_SCLK_IDLE = 1'b0;
  localparam logic LISW_SCLK_HIGH = 1'b1;
  localparam logic LISW_DATA_IDLE = 1'b0;

  // reference line clock and host spacing
  localparam real LISW_RCLK_REF_MHZ   = 2.048;
  localparam int  LISW_CLK_PERIOD_NS  = 10;
  localparam int  LISW_WR_SPACING_US  = 20;
  localparam int  LISW_WR_SPACING_CYC = (LISW_WR_SPACING_US * 1000) / LISW_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LISW_IDLE  = 2'b00,
    LISW_SETUP = 2'b01,
    LISW_SHIFT = 2'b10,
    LISW_HOLD  = 2'b11
  } lisw_state_t;

  // serial port toward the line interface unit
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdata;
    logic byte_sel;
  } lisw_serial_t;

  // pending transfer
  typedef struct packed {
    logic       byte_sel;
    logic [7:0] data;
  } lisw_req_t;

endpackage

/* File: core/lisw_edge_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module lisw_edge_sync
  import lisw_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // asynchronous level in
  input  wire logic async_in,
  // edge pulses out
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule
`default_nettype wire

/* File: core/lisw_writer.sv */
// How it works
// R1: a write to either control byte address starts a serial transfer with no further software action.
// R2: the byte leaves on the serial data output least significant bit first, most significant bit last.
// R3: the block drives its own chip select, serial clock and serial data toward the line interface unit.
// R4: all serial timing runs off the receive line clock, which must be running for a transfer to go out.
// R5: both control byte addresses are write-only and read back as zero.
// R6: the host spaces writes at least 20 us apart so the previous transfer can finish.
// R7: byte one decodes at 18 hex and byte two at 19 hex, each eight bits wide.
// R8: byte one and byte two writes give distinct sequences, told apart by the byte select output.
// R9: transfer timing scales with the receive line clock, nominally 2.048 MHz at 50% duty.
// R10: chip select stays active over the whole byte, eight clock pulses go out, data changes on the falling edge.
// R11: the written byte is held in a register and the request is handed to the line clock edges before shifting.
`timescale 1ns/100ps
`default_nettype none
module lisw_writer
  import lisw_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // parallel register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // receive line clock pin
  input  wire logic       rclk,
  // line interface serial port
  output logic            xcvr_chip_select_n,
  output logic            xcvr_serial_clock,
  output logic            xcvr_serial_data,
  output logic            xcvr_byte_sel,
  // status
  output logic            busy
);

  lisw_state_t  state_r;
  lisw_state_t  state_nxt;
  lisw_req_t    hold_r;
  logic         pend_r;
  logic [7:0]   shift_r;
  logic [2:0]   bit_r;
  lisw_serial_t ser_r;
  logic [7:0]   rdata_r;
  logic         rclk_rise;
  logic         rclk_fall;
  logic         wr_one;
  logic         wr_two;
  logic         start;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction

  assign wr_one = reg_wr & addr_hit(reg_addr, LISW_ADDR_BYTE_ONE); // R7
  assign wr_two = reg_wr & addr_hit(reg_addr, LISW_ADDR_BYTE_TWO); // R7

  // line clock sampled and edge detected
  lisw_edge_sync u_rclk_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (rclk),
    .rise     (rclk_rise),
    .fall     (rclk_fall)
  ); // R4 R9

  // write-only registers read as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= LISW_RD_ZERO;
    end else if (reg_rd) begin
      rdata_r <= LISW_RD_ZERO; // R5
    end
  end

  // holding register and pending request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_r <= '0;
      pend_r <= 1'b0;
    end else begin
      if (wr_one | wr_two) begin
        hold_r.data     <= reg_wdata; // R11
        hold_r.byte_sel <= wr_two;    // R8
      end
      if (wr_one | wr_two) begin
        pend_r <= 1'b1; // R1
      end else if (start) begin
        pend_r <= 1'b0;
      end
    end
  end

  // request taken on a line clock rising edge
  assign start = pend_r & rclk_rise & (state_r == LISW_IDLE) & ~(wr_one | wr_two); // R11

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LISW_IDLE: begin
        if (start) begin
          state_nxt = LISW_SETUP;
        end
      end
      LISW_SETUP: begin
        if (rclk_fall) begin
          state_nxt = LISW_SHIFT;
        end
      end
      LISW_SHIFT: begin
        if (rclk_rise && bit_r == LISW_BIT_LAST) begin
          state_nxt = LISW_HOLD;
        end
      end
      LISW_HOLD: begin
        if (rclk_rise) begin
          state_nxt = LISW_IDLE;
        end
      end
      default: begin
        state_nxt = LISW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= LISW_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // shifter and bit count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_r <= '0;
      bit_r   <= LISW_BIT_FIRST;
    end else if (start) begin
      shift_r <= hold_r.data;
      bit_r   <= LISW_BIT_FIRST;
    end else if (state_r == LISW_SHIFT && rclk_rise) begin
      shift_r <= {1'b0, shift_r[7:1]}; // R2
      bit_r   <= bit_r + 3'h1;
    end
  end

  // serial port outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ser_r.cs_n     <= LISW_CS_IDLE;
      ser_r.sclk     <= LISW_SCLK_IDLE;
      ser_r.sdata    <= LISW_DATA_IDLE;
      ser_r.byte_sel <= 1'b0;
    end else begin
      case (state_r)
        LISW_IDLE: begin
          if (start) begin
            ser_r.cs_n     <= LISW_CS_ACTIVE;  // R3 R10
            ser_r.sdata    <= hold_r.data[0];  // R2
            ser_r.byte_sel <= hold_r.byte_sel; // R8
          end
        end
        LISW_SETUP: begin
          if (rclk_fall) begin
            ser_r.sclk <= LISW_SCLK_HIGH; // R10
          end
        end
        LISW_SHIFT: begin
          if (rclk_rise) begin
            ser_r.sclk <= LISW_SCLK_IDLE;
            if (bit_r != LISW_BIT_LAST) begin
              ser_r.sdata <= shift_r[1]; // R2 R10
            end
          end else if (rclk_fall) begin
            ser_r.sclk <= LISW_SCLK_HIGH; // R10
          end
        end
        LISW_HOLD: begin
          if (rclk_rise) begin
            ser_r.cs_n     <= LISW_CS_IDLE; // R10
            ser_r.sdata    <= LISW_DATA_IDLE;
            ser_r.byte_sel <= 1'b0;
          end
        end
        default: begin
          ser_r.cs_n <= LISW_CS_IDLE;
          ser_r.sclk <= LISW_SCLK_IDLE;
        end
      endcase
    end
  end

  assign xcvr_chip_select_n = ser_r.cs_n;
  assign xcvr_serial_clock  = ser_r.sclk;
  assign xcvr_serial_data   = ser_r.sdata;
  assign xcvr_byte_sel      = ser_r.byte_sel;
  assign reg_rdata          = rdata_r;
  assign busy               = pend_r | (state_r != LISW_IDLE);

endmodule
`default_nettype wire

/* File: dv/lisw_lif_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lisw_lif_model (
  // serial port from the writer
  input  wire logic       reset,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       sdata,
  input  wire logic       sel,
  // what the unit received
  output logic [7:0]      rx_byte,
  output logic            rx_sel,
  output logic [3:0]      rx_bits,
  output logic [7:0]      frames
);
  logic [7:0] shift_r;
  // count cleared as select falls, samples on the rising serial clock
  always @(negedge cs_n or posedge sclk) begin
    if (!cs_n && !sclk) begin
      rx_bits = 4'h0;
    end else if (!cs_n) begin
      shift_r = {sdata, shift_r[7:1]};
      rx_bits = rx_bits + 4'h1;
      rx_sel = sel;
    end
  end
  always @(posedge cs_n or posedge reset) begin
    if (reset) frames = 8'h00;
    else begin
      rx_byte = shift_r;
      frames = frames + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: dv/lisw_writer_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module lisw_writer_chk
  import lisw_pkg::*;
(
  // watched ports
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       rclk,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       xcvr_chip_select_n,
  input wire logic       xcvr_serial_clock,
  input wire logic       xcvr_serial_data,
  input wire logic       xcvr_byte_sel,
  input wire logic       busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [3:0] pulses_r;
  logic       hit;
  assign hit = reg_wr && (reg_addr == 8'h18 || reg_addr == 8'h19);
  // serial clock pulses within one frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) pulses_r <= 4'h0;
    else if (xcvr_chip_select_n) pulses_r <= 4'h0;
    else if ($rose(xcvr_serial_clock)) pulses_r <= pulses_r + 4'h1;
  end
  property p_rd_zero; reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
  property p_start; hit |=> busy; endproperty
  a_start: assert property (p_start) else $error("write did not start");
  property p_ignore; reg_wr && !hit && !busy |=> !busy; endproperty
  a_ignore: assert property (p_ignore) else $error("foreign address started");
  property p_idle; xcvr_chip_select_n |-> !xcvr_serial_clock && !xcvr_serial_data && !xcvr_byte_sel; endproperty
  a_idle: assert property (p_idle) else $error("port not idle");
  property p_sclk_cs; xcvr_serial_clock |-> !xcvr_chip_select_n; endproperty
  a_sclk_cs: assert property (p_sclk_cs) else $error("clock outside select");
  property p_data_edge; $changed(xcvr_serial_data) |-> !xcvr_serial_clock; endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved while clock high");
  property p_sel_hold; !xcvr_chip_select_n && !$past(xcvr_chip_select_n) |-> $stable(xcvr_byte_sel); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("byte select moved");
  property p_busy_cs; !xcvr_chip_select_n |-> busy; endproperty
  a_busy_cs: assert property (p_busy_cs) else $error("frame without busy");
  property p_eight; $rose(xcvr_chip_select_n) |-> pulses_r == 4'h8; endproperty
  a_eight: assert property (p_eight) else $error("pulse count not eight");
  // serial clock edges follow line clock edges through the two-flop sampler
  property p_sclk_rise; $rose(xcvr_serial_clock) |-> $past(rclk, 4) && !$past(rclk, 3); endproperty
  a_sclk_rise: assert property (p_sclk_rise) else $error("serial clock rose off a line clock fall");
  property p_sclk_fall; $fell(xcvr_serial_clock) |-> !$past(rclk, 4) && $past(rclk, 3); endproperty
  a_sclk_fall: assert property (p_sclk_fall) else $error("serial clock fell off a line clock rise");
  c_two: cover property (hit && reg_addr == 8'h19);
  c_end: cover property ($rose(xcvr_chip_select_n));
  c_sel: cover property ($fell(xcvr_chip_select_n) ##1 xcvr_byte_sel);
endmodule
bind lisw_writer lisw_writer_chk chk_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xcvr_chip_select_n(xcvr_chip_select_n),
  .xcvr_serial_clock(xcvr_serial_clock), .xcvr_serial_data(xcvr_serial_data),
  .xcvr_byte_sel(xcvr_byte_sel), .busy(busy), .rclk(rclk));
`default_nettype wire

/* File: dv/line_interface_serial_writer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module line_interface_serial_writer_tb
  import lisw_pkg::*;
;
  logic       clk, reset, reg_wr, reg_rd, rclk, run, cs_n, sclk, sdata, sel, busy, rx_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_byte, frames, n;
  logic [3:0] rx_bits;
  int         num_errors = 0;
  int         checks = 0;
  lisw_writer dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rclk(rclk), .xcvr_chip_select_n(cs_n), .xcvr_serial_clock(sclk),
    .xcvr_serial_data(sdata), .xcvr_byte_sel(sel), .busy(busy));
  lisw_lif_model lif_u (.reset(reset), .cs_n(cs_n), .sclk(sclk), .sdata(sdata), .sel(sel), .rx_byte(rx_byte),
    .rx_sel(rx_sel), .rx_bits(rx_bits), .frames(frames));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // line clock, unrelated phase, can be stopped
  initial begin
    rclk = 1'b0;
    #37;
    forever #80 rclk = run ? ~rclk : rclk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task gap;
    repeat (LISW_WR_SPACING_CYC) @(posedge clk);
  endtask
  task automatic t_bytes;
    logic [7:0] a[4] = '{8'h18, 8'h19, 8'h18, 8'h19};
    logic [7:0] d[4] = '{8'ha5, 8'h3c, 8'h01, 8'h80};
    for (int i = 0; i < 4; i++) begin
      n = frames;
      wr(a[i], d[i]);
      gap;
      chk(frames, n + 8'h01);
      chk(rx_byte, d[i]);
      chk({7'h0, rx_sel}, {7'h0, a[i] == 8'h19});
      chk({4'h0, rx_bits}, 8'h08);
    end
    $display("test bytes done");
  endtask
  task t_read;
    wr(8'h18, 8'h5a);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      #1;
      reg_addr = 8'h18 + i[7:0];
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      chk(reg_rdata, 8'h00);
    end
    gap;
    $display("test read done");
  endtask
  task t_other;
    n = frames;
    wr(8'h17, 8'hff);
    wr(8'h1a, 8'hff);
    gap;
    chk(frames, n);
    $display("test other done");
  endtask
  task t_no_rclk;
    run = 1'b0;
    n = frames;
    wr(8'h19, 8'hc3);
    repeat (500) @(posedge clk);
    chk(frames, n);
    chk({7'h0, busy}, 8'h01);
    run = 1'b1;
    gap;
    chk(frames, n + 8'h01);
    chk(rx_byte, 8'hc3);
    $display("test no line clock done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    summarize;
  end
  initial begin
    reset = 1'b1;
    run = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    chk({3'h0, cs_n, sclk, sdata, sel, busy}, 8'h10);
    t_bytes;
    t_read;
    t_other;
    t_no_rclk;
    summarize;
  end
endmodule
`default_nettype wire
